// ---- design/cscf_top.sv ----
// card status-change flags, mask/route configuration and interrupt request
`timescale 1ns/10ps
module cscf_top
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_RD,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic CARD_DETECT_PIN_A_N,
    input wire logic CARD_DETECT_PIN_B_N,
    input wire logic CARD_READY,
    input wire logic BATTERY_LOW_N,
    input wire logic BATTERY_RING_SHARED_PIN,
    input wire logic IO_CARD,
    input wire logic RING_FUNCTION_ENABLE,
    input wire logic CLEAR_BY_WRITE,
    output logic SOCKET_CHANGE_EVENT,
    output logic [3:0] CHANGE_IRQ_ROUTE_SELECT
);
    cscf_pkg::cscf_top_s s;
    cscf_pkg::cscf_top_s next_s;

    // =====================================================================
    // pin synchronisation
    cscf_pin_if #(.N(cscf_pkg::PIN_COUNT)) pins ();

    logic [4:0] raw_pins;

    // pin vector order follows the package indices
    assign raw_pins = {BATTERY_RING_SHARED_PIN, BATTERY_LOW_N, CARD_READY,
                       CARD_DETECT_PIN_B_N, CARD_DETECT_PIN_A_N};

    cscf_pin_sync #(.N(cscf_pkg::PIN_COUNT)) u_sync
    (
        .clk(CLK),
        .arst_n(ARST_N),
        .raw(raw_pins),
        .pins(pins)
    );

    // =====================================================================
    // event detection
    logic cd_change;
    logic ready_rise;
    logic warn_fall;
    logic shared_fall;
    logic ring_active;
    logic [3:0] set_vec;
    logic [3:0] clr_vec;
    logic [3:0] mask;
    logic [7:0] status_view;
    logic rd_status;
    logic wr_status;
    logic rd_config;
    logic wr_config;

    // edges compare the synchronised sample against the one before it
    always_comb
    begin
        cd_change = pins.valid
            && ((pins.level[cscf_pkg::PIN_CD_A] != pins.prev[cscf_pkg::PIN_CD_A])
            || (pins.level[cscf_pkg::PIN_CD_B] != pins.prev[cscf_pkg::PIN_CD_B]));
        ready_rise = pins.valid && pins.level[cscf_pkg::PIN_READY]
            && !pins.prev[cscf_pkg::PIN_READY];
        warn_fall = pins.valid && !pins.level[cscf_pkg::PIN_WARN_N]
            && pins.prev[cscf_pkg::PIN_WARN_N];
        shared_fall = pins.valid && !pins.level[cscf_pkg::PIN_SHARED]
            && pins.prev[cscf_pkg::PIN_SHARED];
        // ring indicate is active low on the shared pin
        ring_active = RING_FUNCTION_ENABLE && !pins.level[cscf_pkg::PIN_SHARED];
    end

    assign mask = s.cfg[3:0];

    // sources are gated by their mask before they can set a flag
    always_comb
    begin
        set_vec = cscf_pkg::FLAGS_RESET;
        set_vec[cscf_pkg::BIT_DETECT] = cd_change && mask[cscf_pkg::BIT_DETECT];
        set_vec[cscf_pkg::BIT_READY] = ready_rise && !IO_CARD
            && mask[cscf_pkg::BIT_READY];
        set_vec[cscf_pkg::BIT_WARN] = warn_fall && !IO_CARD
            && mask[cscf_pkg::BIT_WARN];
        // in ring mode the shared pin no longer latches dead/status events
        set_vec[cscf_pkg::BIT_DEAD] = shared_fall && !RING_FUNCTION_ENABLE
            && mask[cscf_pkg::BIT_DEAD];
    end

    // =====================================================================
    // register decode and readback
    assign rd_status = REG_RD && (REG_ADDR == cscf_pkg::OFS_STATUS);
    assign wr_status = REG_WR && (REG_ADDR == cscf_pkg::OFS_STATUS);
    assign rd_config = REG_RD && (REG_ADDR == cscf_pkg::OFS_CONFIG);
    assign wr_config = REG_WR && (REG_ADDR == cscf_pkg::OFS_CONFIG);

    // visible status: masked bits, card-type forcing and ring level applied at read
    always_comb
    begin
        status_view = cscf_pkg::STATUS_RESET;
        status_view[7:4] = cscf_pkg::RSVD_ZERO;
        status_view[3:0] = s.flags & mask;
        if (IO_CARD)
        begin
            status_view[cscf_pkg::BIT_READY] = 1'b0;
            status_view[cscf_pkg::BIT_WARN] = 1'b0;
        end
        if (RING_FUNCTION_ENABLE)
        begin
            status_view[cscf_pkg::BIT_DEAD] = ring_active && mask[cscf_pkg::BIT_DEAD];
        end
    end

    // only the method picked by the clear-mode input may clear
    always_comb
    begin
        clr_vec = cscf_pkg::FLAGS_RESET;
        if (rd_status && !CLEAR_BY_WRITE)
        begin
            clr_vec = cscf_pkg::FLAGS_ALL;
        end
        else if (wr_status && CLEAR_BY_WRITE)
        begin
            clr_vec = REG_WDATA[3:0];
        end
    end

    // =====================================================================
    // next state
    always_comb
    begin
        next_s = s;
        // a set in the clearing cycle survives so no event is lost
        next_s.flags = (s.flags & ~clr_vec) | set_vec;
        if (wr_config)
        begin
            next_s.cfg = REG_WDATA;
        end
        // read data is the value before any read-clear takes effect
        if (rd_status)
        begin
            next_s.rdata = status_view;
        end
        else if (rd_config)
        begin
            next_s.rdata = s.cfg;
        end
        else if (REG_RD)
        begin
            next_s.rdata = cscf_pkg::RDATA_RESET;
        end
        // request follows any visible flag, one cycle behind
        next_s.irq = (status_view != cscf_pkg::STATUS_RESET);
    end

    // state register
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // outputs straight from state
    assign REG_RDATA = s.rdata;
    assign SOCKET_CHANGE_EVENT = s.irq;
    assign CHANGE_IRQ_ROUTE_SELECT = s.cfg[7:4];

    // =====================================================================
    // checks
    logic [3:0] wdata_lo;
    logic [3:0] wdata_hi;
    logic ring_pin_level;

    assign wdata_lo = REG_WDATA[3:0];
    assign wdata_hi = REG_WDATA[7:4];
    assign ring_pin_level = pins.level[cscf_pkg::PIN_SHARED];

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    a_masked_read_zero:
    assert property (rd_status && !mask[cscf_pkg::BIT_DETECT]
        |=> !REG_RDATA[cscf_pkg::BIT_DETECT])
    else $error("masked detect flag read back as one");

    a_irq_follows:
    assert property ((status_view != cscf_pkg::STATUS_RESET) |=> SOCKET_CHANGE_EVENT)
    else $error("visible flag did not raise the interrupt");

    a_irq_quiet:
    assert property ((status_view == cscf_pkg::STATUS_RESET) |=> !SOCKET_CHANGE_EVENT)
    else $error("interrupt raised with no visible flag");

    a_read_clears:
    assert property (rd_status && !CLEAR_BY_WRITE && (set_vec == cscf_pkg::FLAGS_RESET)
        |=> s.flags == cscf_pkg::FLAGS_RESET)
    else $error("read in read-clear mode left flags set");

    a_write_clears:
    assert property (wr_status && CLEAR_BY_WRITE && (set_vec == cscf_pkg::FLAGS_RESET)
        |=> (s.flags & $past(wdata_lo)) == cscf_pkg::FLAGS_RESET)
    else $error("write-one did not clear the flag");

    // a read and a write in one cycle may legally clear through the selected method
    a_wrong_method_keeps:
    assert property (((rd_status && CLEAR_BY_WRITE && !wr_status)
        || (wr_status && !CLEAR_BY_WRITE && !rd_status))
        |=> (s.flags & $past(s.flags)) == $past(s.flags))
    else $error("flag cleared by the method not selected");

    a_reserved_zero:
    assert property (rd_status |=> REG_RDATA[7:4] == cscf_pkg::RSVD_ZERO)
    else $error("reserved status bits not zero");

    a_detect_sets:
    assert property (cd_change && mask[cscf_pkg::BIT_DETECT]
        |=> s.flags[cscf_pkg::BIT_DETECT]
        ##1 (s.flags[cscf_pkg::BIT_DETECT] || $past(clr_vec[cscf_pkg::BIT_DETECT])))
    else $error("detect change not latched and held");

    a_ready_sets:
    assert property (ready_rise && !IO_CARD && mask[cscf_pkg::BIT_READY]
        |=> s.flags[cscf_pkg::BIT_READY])
    else $error("ready rise not latched");

    a_io_forces_zero:
    assert property (rd_status && IO_CARD |=> REG_RDATA[2:1] == 2'h0)
    else $error("I/O card read ready or warning as one");

    a_warn_sets:
    assert property (warn_fall && !IO_CARD && mask[cscf_pkg::BIT_WARN]
        |=> s.flags[cscf_pkg::BIT_WARN])
    else $error("battery warning not latched");

    a_dead_sets:
    assert property (shared_fall && !RING_FUNCTION_ENABLE && mask[cscf_pkg::BIT_DEAD]
        |=> s.flags[cscf_pkg::BIT_DEAD])
    else $error("battery dead or status change not latched");

    a_ring_level:
    assert property (rd_status && RING_FUNCTION_ENABLE && mask[cscf_pkg::BIT_DEAD]
        |=> REG_RDATA[cscf_pkg::BIT_DEAD] == !$past(ring_pin_level))
    else $error("ring mode bit zero does not follow the pin");

    a_config_rw:
    assert property (wr_config ##1 rd_config && !REG_WR
        |=> REG_RDATA == $past(s.cfg))
    else $error("config readback mismatch");

    a_route_out:
    assert property (wr_config |=> CHANGE_IRQ_ROUTE_SELECT == $past(wdata_hi))
    else $error("route select not taken from config write");

    a_detect_gated:
    assert property (!mask[cscf_pkg::BIT_DETECT] && !s.flags[cscf_pkg::BIT_DETECT]
        |=> !s.flags[cscf_pkg::BIT_DETECT])
    else $error("detect flag set while disabled");

    a_set_wins:
    assert property ((set_vec & clr_vec) != cscf_pkg::FLAGS_RESET
        |=> (s.flags & $past(set_vec)) == $past(set_vec))
    else $error("event lost against a same-cycle clear");

    a_flags_hold:
    assert property ((clr_vec == cscf_pkg::FLAGS_RESET)
        |=> (s.flags & $past(s.flags)) == $past(s.flags))
    else $error("flag dropped without a clear");

    a_edge_needs_sync:
    assert property (ready_rise |-> (pins.prev == $past(pins.level))
        && pins.level[cscf_pkg::PIN_READY] && !pins.prev[cscf_pkg::PIN_READY])
    else $error("ready edge without synchronised rise");
endmodule

// ---- shared/cscf_pkg.sv ----
// constants and state types for the card status-change flag block
package cscf_pkg;

    // =====================================================================
    // register port geometry and offsets
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CONFIG = 8'h05;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // =====================================================================
    // status flag positions, shared with the matching mask bits
    localparam int FLAG_W = 4;
    localparam int BIT_DETECT = 3;
    localparam int BIT_READY = 2;
    localparam int BIT_WARN = 1;
    localparam int BIT_DEAD = 0;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [3:0] FLAGS_ALL = 4'hf;
    localparam logic [3:0] RSVD_ZERO = 4'h0;

    // =====================================================================
    // configuration field: interrupt routing select
    localparam int ROUTE_LSB = 4;
    localparam int ROUTE_W = 4;
    localparam logic [3:0] ROUTE_NONE = 4'h0;

    // =====================================================================
    // socket pin order inside the synchroniser vector
    localparam int PIN_COUNT = 5;
    localparam int PIN_CD_A = 0;
    localparam int PIN_CD_B = 1;
    localparam int PIN_READY = 2;
    localparam int PIN_WARN_N = 3;
    localparam int PIN_SHARED = 4;
    localparam logic [4:0] PIN_RESET = 5'h00;

    // =====================================================================
    // synchroniser warm-up: edges until the previous sample is genuine
    localparam logic [1:0] WARM_RESET = 2'h0;
    localparam logic [1:0] WARM_DONE = 2'h3;

    // whole state of the top module
    typedef struct packed {
        logic [3:0] flags;
        logic [7:0] cfg;
        logic [7:0] rdata;
        logic irq;
    } cscf_top_s;

endpackage

// ---- shared/cscf_pin_if.sv ----
// synchronised socket pin levels handed from the synchroniser to the flag logic
`timescale 1ns/10ps
interface cscf_pin_if #(
    parameter int N = 5
);
    logic [N-1:0] level;
    logic [N-1:0] prev;
    logic valid;

    modport src (output level, output prev, output valid);
    modport dst (input level, input prev, input valid);
endinterface

// ---- design/cscf_pin_sync.sv ----
// two-flop synchroniser with a previous-sample stage for edge detection
`timescale 1ns/10ps
module cscf_pin_sync #(
    parameter int N = 5
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [N-1:0] raw,
    cscf_pin_if.src pins
);
    typedef struct packed {
        logic [N-1:0] meta;
        logic [N-1:0] sync;
        logic [N-1:0] prev;
        logic [1:0] warm;
    } cscf_sync_s;

    cscf_sync_s s;
    cscf_sync_s next_s;

    // meta feeds sync only; warm counter masks the false edge after reset
    always_comb
    begin
        next_s = s;
        next_s.meta = raw;
        next_s.sync = s.meta;
        next_s.prev = s.sync;
        if (s.warm != cscf_pkg::WARM_DONE)
        begin
            next_s.warm = s.warm + 2'h1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // outputs never expose the first stage
    assign pins.level = s.sync;
    assign pins.prev = s.prev;
    assign pins.valid = (s.warm == cscf_pkg::WARM_DONE);
endmodule

// ---- testbench/cscf_card.sv ----
// behavioural 16-bit card that drives the socket status pins
`timescale 1ns/10ps
module cscf_card
(
    input wire logic clk,
    output logic det_a_n,
    output logic det_b_n,
    output logic ready,
    output logic low_n,
    output logic shared_n
);
    // =====================================================================
    // pin levels: card present, not ready, battery fine, no status change
    logic [4:0] pins = 5'h18;
    assign {shared_n, low_n, ready, det_b_n, det_a_n} = pins;

    // change one pin just after an edge and hold it well past sync latency
    task automatic set_pin(input int idx, input logic v);
        @(posedge clk);
        #1 pins[idx] = v;
        repeat (6) @(posedge clk);
    endtask
endmodule

// ---- testbench/cscf_top_tb.sv ----
// self-checking bench for the card status-change flag block
`timescale 1ns/10ps
module cscf_top_tb;
    // =====================================================================
    // stimulus and observed signals
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic io = 1'b0;
    logic ring = 1'b0;
    logic cbw = 1'b0;
    logic [7:0] rdata;
    logic irq;
    logic [3:0] route;
    logic da, db, rdy, low, shr;
    int err_count = 0;
    int checked = 0;

    cscf_card i_cscf_card (.clk(clk), .det_a_n(da), .det_b_n(db), .ready(rdy),
        .low_n(low), .shared_n(shr));
    cscf_top i_cscf_top (.CLK(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_RD(rd),
        .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata), .CARD_DETECT_PIN_A_N(da),
        .CARD_DETECT_PIN_B_N(db), .CARD_READY(rdy), .BATTERY_LOW_N(low),
        .BATTERY_RING_SHARED_PIN(shr), .IO_CARD(io), .RING_FUNCTION_ENABLE(ring),
        .CLEAR_BY_WRITE(cbw), .SOCKET_CHANGE_EVENT(irq), .CHANGE_IRQ_ROUTE_SELECT(route));

    // 100 ns period
    initial
    begin
        forever #50 clk = ~clk;
    end

    // =====================================================================
    // shared helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // strobes are one cycle wide and held across the sampling edge
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 {addr, wdata, wr} = {a, d, 1'b1};
        @(posedge clk);
        #1 wr = 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 {addr, rd} = {a, 1'b1};
        @(posedge clk);
        #1 rd = 1'b0;
        chk(rdata, exp);
    endtask

    // bounded wait; running out of cycles ends the run
    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        while (irq !== exp && n < 12)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk({7'h00, irq}, {7'h00, exp});
        if (irq !== exp)
            stop_test();
    endtask

    task automatic ctl(input logic i, input logic r, input logic c);
        @(posedge clk);
        #1 {io, ring, cbw} = {i, r, c};
    endtask

    // =====================================================================
    // scenarios
    task automatic t_regs();
        reg_rd(8'h04, 8'h00);
        reg_rd(8'h05, 8'h00);
        chk({4'h0, route}, 8'h00);
        reg_wr(8'h05, 8'ha0);
        reg_rd(8'h05, 8'ha0);
        chk({4'h0, route}, 8'h0a);
        reg_wr(8'h09, 8'hff);
        reg_rd(8'h09, 8'h00);
        reg_rd(8'h05, 8'ha0);
        $display("test regs done");
    endtask

    task automatic t_masked();
        reg_wr(8'h05, 8'h30);
        i_cscf_card.set_pin(2, 1'b1);
        i_cscf_card.set_pin(1, 1'b1);
        chk({7'h00, irq}, 8'h00);
        reg_wr(8'h05, 8'h3f);
        reg_rd(8'h04, 8'h00);
        $display("test masked done");
    endtask

    task automatic t_detect();
        reg_wr(8'h05, 8'h08);
        i_cscf_card.set_pin(0, 1'b1);
        wait_irq(1'b1);
        reg_wr(8'h04, 8'h08);
        reg_rd(8'h04, 8'h08);
        wait_irq(1'b0);
        reg_rd(8'h04, 8'h00);
        i_cscf_card.set_pin(1, 1'b0);
        reg_rd(8'h04, 8'h08);
        $display("test detect done");
    endtask

    task automatic t_memory();
        reg_wr(8'h05, 8'h0f);
        i_cscf_card.set_pin(2, 1'b0);
        i_cscf_card.set_pin(2, 1'b1);
        i_cscf_card.set_pin(3, 1'b0);
        i_cscf_card.set_pin(4, 1'b0);
        reg_rd(8'h04, 8'h07);
        reg_rd(8'h04, 8'h00);
        i_cscf_card.set_pin(3, 1'b1);
        i_cscf_card.set_pin(4, 1'b1);
        $display("test memory done");
    endtask

    task automatic t_io();
        ctl(1'b1, 1'b0, 1'b0);
        reg_rd(8'h04, 8'h00);
        i_cscf_card.set_pin(2, 1'b0);
        i_cscf_card.set_pin(2, 1'b1);
        i_cscf_card.set_pin(3, 1'b0);
        reg_rd(8'h04, 8'h00);
        i_cscf_card.set_pin(4, 1'b0);
        reg_rd(8'h04, 8'h01);
        i_cscf_card.set_pin(3, 1'b1);
        i_cscf_card.set_pin(4, 1'b1);
        ctl(1'b0, 1'b0, 1'b0);
        $display("test io done");
    endtask

    task automatic t_w1c();
        ctl(1'b0, 1'b0, 1'b1);
        reg_rd(8'h04, 8'h00);
        i_cscf_card.set_pin(0, 1'b0);
        reg_rd(8'h04, 8'h08);
        reg_rd(8'h04, 8'h08);
        reg_wr(8'h04, 8'h07);
        reg_rd(8'h04, 8'h08);
        reg_wr(8'h04, 8'h08);
        reg_rd(8'h04, 8'h00);
        wait_irq(1'b0);
        ctl(1'b0, 1'b0, 1'b0);
        $display("test w1c done");
    endtask

    task automatic t_ring();
        ctl(1'b0, 1'b1, 1'b0);
        reg_wr(8'h05, 8'h01);
        i_cscf_card.set_pin(4, 1'b0);
        reg_rd(8'h04, 8'h01);
        reg_rd(8'h04, 8'h01);
        wait_irq(1'b1);
        i_cscf_card.set_pin(4, 1'b1);
        reg_rd(8'h04, 8'h00);
        wait_irq(1'b0);
        ctl(1'b0, 1'b0, 1'b0);
        $display("test ring done");
    endtask

    // =====================================================================
    // main sequence; waits past the synchroniser warm-up after reset
    initial
    begin
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_masked();
        t_detect();
        t_memory();
        t_io();
        t_w1c();
        t_ring();
        stop_test();
    end
endmodule
